// ===== rtl/fgc_pkg.sv
package fgc_pkg;

	// ***************************************************************
	// Clock and time bases
	// ***************************************************************
	localparam int CLK_HZ         = 25000000;
	localparam int GATE_TICK_HZ   = 1000;
	localparam int REF_MID_HZ     = 100000;
	localparam int REF_HIGH_HZ    = 900000;
	// Nearest whole divider; 900 kHz does not divide 25 MHz evenly
	localparam int GATE_TICK_CYC  = (CLK_HZ + GATE_TICK_HZ / 2) / GATE_TICK_HZ;
	localparam int REF_MID_CYC    = (CLK_HZ + REF_MID_HZ / 2) / REF_MID_HZ;
	localparam int REF_HIGH_CYC   = (CLK_HZ + REF_HIGH_HZ / 2) / REF_HIGH_HZ;

	// Gate lengths in 1 ms ticks
	localparam logic [3:0] GATE_LEN_1MS  = 4'h1;
	localparam logic [3:0] GATE_LEN_4MS  = 4'h4;
	localparam logic [3:0] GATE_LEN_8MS  = 4'h8;
	localparam logic [3:0] GATE_LEN_STOP = 4'h1;

	// ***************************************************************
	// Peripheral addresses and fields
	// ***************************************************************
	localparam logic [6:0] ADDR_GATE_STATUS   = 7'h04;
	localparam logic [6:0] ADDR_COUNT_CONTROL = 7'h23;
	localparam logic [6:0] ADDR_COUNT_VALUE   = 7'h43;
	localparam int         START_BIT          = 1;
	localparam int         CLEAR_BIT          = 0;
	localparam logic [3:0] READ_ZERO          = 4'h0;
	localparam logic [15:0] COUNT_RESET       = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'hFFFF;

	// ***************************************************************
	// Mode encodings
	// ***************************************************************
	localparam logic [1:0] FN_EXT_GATE  = 2'h0;
	localparam logic [1:0] FN_AM_DIRECT = 2'h1;
	localparam logic [1:0] FN_FM_HALVED = 2'h2;
	localparam logic [1:0] FN_FM_DIRECT = 2'h3;
	localparam logic [1:0] GT_1MS       = 2'h0;
	localparam logic [1:0] GT_4MS       = 2'h1;
	localparam logic [1:0] GT_8MS       = 2'h2;
	localparam logic [1:0] GT_OPEN      = 2'h3;
	localparam logic [1:0] GP_PIN0      = 2'h0;
	localparam logic [1:0] GP_PIN1      = 2'h1;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_WAIT  = 5'h02,
		ST_TIMED = 5'h04,
		ST_FREE  = 5'h08,
		ST_EXT   = 5'h10
	} fgc_state_t;

endpackage

// ===== rtl/fgc_tick_gen.sv
`timescale 1ns/100ps
module fgc_tick_gen #(
	parameter int DIV = 2
) (
	input  wire logic core_clk,
	input  wire logic rst,
	output logic      tick
);
	localparam int             W    = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0]   LAST = W'(DIV - 1);
	localparam logic [W-1:0]   ONE  = W'(1);

	logic [W-1:0] phase;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase <= '0;
			tick  <= 1'b0;
		end else if (phase == LAST) begin
			phase <= '0;
			tick  <= 1'b1;
		end else begin
			phase <= phase + ONE;
			tick  <= 1'b0;
		end
	end
endmodule

// ===== rtl/fgc_gate_counter.sv
`timescale 1ns/100ps
module fgc_gate_counter
	import fgc_pkg::*;
#(
	parameter int TICK_CYC  = GATE_TICK_CYC,
	parameter int MID_CYC   = REF_MID_CYC,
	parameter int HIGH_CYC  = REF_HIGH_CYC,
	parameter int CNT_W     = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clockStop,
	input  wire logic [6:0]       periAddr,
	input  wire logic             winWrite,
	input  wire logic             winRead,
	input  wire logic [3:0]       winWData,
	input  wire logic             bufLoad,
	input  wire logic [1:0]       functionSel,
	input  wire logic [1:0]       gateTimeSel,
	input  wire logic [1:0]       gatePinSel,
	input  wire logic             fmInputPin,
	input  wire logic             amInputPin,
	input  wire logic             gatePin0,
	input  wire logic             gatePin1,
	output logic [3:0]            winRData,
	output logic [CNT_W-1:0]      bufRData,
	output logic                  gateOpen
);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	function automatic logic [3:0] gateTicks(input logic [1:0] sel);
		unique case (sel)
			GT_1MS:  gateTicks = GATE_LEN_1MS;
			GT_4MS:  gateTicks = GATE_LEN_4MS;
			GT_8MS:  gateTicks = GATE_LEN_8MS;
			GT_OPEN: gateTicks = GATE_LEN_STOP;
		endcase
	endfunction

	fgc_state_t       state;
	fgc_state_t       next_state;
	logic [3:0]       tickCnt;
	logic [3:0]       next_tickCnt;
	logic [3:0]       gateLen;
	logic [CNT_W-1:0] count;
	logic             fmPrev;
	logic             amPrev;
	logic             gate0Prev;
	logic             gate1Prev;
	logic             fmHalf;
	logic             freeSelPrev;
	logic             tickLow;
	logic             tickMid;
	logic             tickHigh;
	logic             extMode;
	logic             ctrlWrite;
	logic             startPulse;
	logic             clearPulse;
	logic             sigEdge;
	logic             refTick;
	logic             gatePinRise;
	logic             freeSel;
	logic             freeReq;
	logic             countInc;
	logic             gateFlag;
	logic [31:0]      openLen;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// ***************************************************************
	// Time bases
	// ***************************************************************
	fgc_tick_gen #(.DIV(TICK_CYC)) uTickLow (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tickLow)
	);
	fgc_tick_gen #(.DIV(MID_CYC)) uTickMid (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tickMid)
	);
	fgc_tick_gen #(.DIV(HIGH_CYC)) uTickHigh (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tickHigh)
	);

	// ***************************************************************
	// Input edges
	// ***************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fmPrev      <= 1'b0;
			amPrev      <= 1'b0;
			gate0Prev   <= 1'b0;
			gate1Prev   <= 1'b0;
			freeSelPrev <= 1'b0;
		end else begin
			fmPrev      <= fmInputPin;
			amPrev      <= amInputPin;
			gate0Prev   <= gatePin0;
			gate1Prev   <= gatePin1;
			freeSelPrev <= freeSel;
		end
	end

	// Divide-by-two stage on the FM input
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fmHalf <= 1'b0;
		end else if (fmInputPin & ~fmPrev) begin
			fmHalf <= ~fmHalf;
		end
	end

	always_comb begin
		unique case (functionSel)
			FN_AM_DIRECT: sigEdge = amInputPin & ~amPrev;
			FN_FM_HALVED: sigEdge = fmInputPin & ~fmPrev & ~fmHalf;
			FN_FM_DIRECT: sigEdge = fmInputPin & ~fmPrev;
			FN_EXT_GATE:  sigEdge = 1'b0;
		endcase
	end

	always_comb begin
		unique case (gateTimeSel)
			GT_1MS:  refTick = tickLow;
			GT_4MS:  refTick = tickMid;
			GT_8MS:  refTick = tickHigh;
			GT_OPEN: refTick = 1'b0;
		endcase
	end

	always_comb begin
		if (gatePinSel == GP_PIN0) begin
			gatePinRise = gatePin0 & ~gate0Prev;
		end else if (gatePinSel == GP_PIN1) begin
			gatePinRise = gatePin1 & ~gate1Prev;
		end else begin
			gatePinRise = 1'b0;
		end
	end

	// ***************************************************************
	// Control decode
	// ***************************************************************
	assign extMode    = (functionSel == FN_EXT_GATE);
	assign ctrlWrite  = winWrite & (periAddr == ADDR_COUNT_CONTROL);
	assign startPulse = ctrlWrite & winWData[START_BIT];
	assign clearPulse = ctrlWrite & winWData[CLEAR_BIT];
	assign freeSel    = (gateTimeSel == GT_OPEN);
	// Opens on the selection itself, so a start can still close it
	assign freeReq    = freeSel & ~freeSelPrev & ~extMode;

	// ***************************************************************
	// Gate sequencer
	// ***************************************************************
	always_comb begin
		next_state   = state;
		next_tickCnt = tickCnt;
		unique case (state)
			ST_IDLE: begin
				if (startPulse) begin
					next_state = ST_WAIT;
				end else if (freeReq) begin
					next_state = ST_FREE;
				end
			end
			ST_WAIT: begin
				next_tickCnt = 4'h0;
				if (startPulse) begin
					next_state = ST_WAIT;
				end else if (extMode & gatePinRise) begin
					next_state = ST_EXT;
				end else if (~extMode & tickLow) begin
					next_state = ST_TIMED;
				end
			end
			ST_TIMED: begin
				if (startPulse) begin
					next_state = ST_WAIT;
				end else if (tickLow) begin
					if (tickCnt == gateLen - 4'h1) begin
						next_state = ST_IDLE;
					end else begin
						next_tickCnt = tickCnt + 4'h1;
					end
				end
			end
			ST_FREE: begin
				if (startPulse) begin
					next_state = ST_WAIT;
				end else if (~freeSel) begin
					next_state = ST_IDLE;
				end
			end
			ST_EXT: begin
				if (startPulse) begin
					next_state = ST_WAIT;
				end else if (gatePinRise) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (clockStop) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state   <= ST_IDLE;
			tickCnt <= 4'h0;
		end else begin
			state   <= next_state;
			tickCnt <= next_tickCnt;
		end
	end

	// Length fixed at start; a later select change waits for restart
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gateLen <= GATE_LEN_1MS;
		end else if (startPulse) begin
			gateLen <= gateTicks(gateTimeSel);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gateOpen <= 1'b0;
		end else begin
			gateOpen <= (next_state == ST_TIMED) | (next_state == ST_FREE) |
				(next_state == ST_EXT);
		end
	end

	// High through arm and timed or external open; low in the open-setting (free) gate
	assign gateFlag = (state == ST_WAIT) | (state == ST_TIMED) |
		(state == ST_EXT);

	// ***************************************************************
	// Counter
	// ***************************************************************
	// Deselected pin gives no edges, so an open gate stops counting
	assign countInc = (((state == ST_TIMED) | (state == ST_FREE)) & sigEdge) |
		((state == ST_EXT) & refTick);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= COUNT_RESET;
		end else if (clearPulse | clockStop) begin
			count <= COUNT_RESET;
		end else if (countInc) begin
			count <= count + CNT_ONE;
		end
	end

	// ***************************************************************
	// Peripheral read side
	// ***************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			winRData <= READ_ZERO;
		end else if (winRead) begin
			if (periAddr == ADDR_GATE_STATUS) begin
				winRData <= {3'b000, gateFlag};
			end else begin
				winRData <= READ_ZERO;
			end
		end
	end

	// Reading mid-gate returns a moving value; software must wait
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bufRData <= COUNT_RESET;
		end else if (bufLoad & (periAddr == ADDR_COUNT_VALUE)) begin
			bufRData <= count;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			openLen <= 32'h0000_0000;
		end else if (state == ST_TIMED) begin
			openLen <= openLen + 32'h0000_0001;
		end else begin
			openLen <= 32'h0000_0000;
		end
	end

	count_inc_a: assert property (countInc & ~clearPulse & ~clockStop &
		(count != COUNT_MAX) |=> count == $past(count) + CNT_ONE)
		else $error("count did not step by one");
	count_wrap_a: assert property (countInc & ~clearPulse & ~clockStop &
		(count == COUNT_MAX) |=> count == COUNT_RESET)
		else $error("count did not wrap to zero");
	count_clear_a: assert property (clearPulse |=>
		count == COUNT_RESET)
		else $error("clear did not zero count");
	start_arms_a: assert property (startPulse & ~clockStop |=>
		(state == ST_WAIT) && gateFlag)
		else $error("start did not raise flag");
	timed_len_a: assert property (($past(state) == ST_TIMED) &&
		(state == ST_IDLE) && !$past(clockStop) |->
		openLen == 32'(gateLen) * TICK_CYC)
		else $error("timed gate length wrong");
	free_open_a: assert property (freeReq & (state == ST_IDLE) &
		~startPulse & ~clockStop |=> gateOpen && (state == ST_FREE))
		else $error("open setting did not open gate");
	free_end_a: assert property ((state == ST_FREE) & ~freeSel &
		~startPulse |=> state == ST_IDLE)
		else $error("fixed time did not end open gate");
	ext_open_a: assert property ((state == ST_WAIT) & extMode &
		gatePinRise & ~startPulse & ~clockStop |=> state == ST_EXT
		##0 gateOpen)
		else $error("gate pin rise did not open gate");
	zero_start_a: assert property (ctrlWrite & ~winWData[START_BIT] &
		(state == ST_IDLE) & ~freeReq |=> state == ST_IDLE)
		else $error("zero start bit had an effect");
	ctrl_read_a: assert property (winRead &
		(periAddr == ADDR_COUNT_CONTROL) |=> winRData == READ_ZERO)
		else $error("control read not zero");
	status_read_a: assert property (winRead &
		(periAddr == ADDR_GATE_STATUS) |=>
		(winRData[3:1] == 3'b000) && (winRData[0] == $past(gateFlag)))
		else $error("status read wrong");
	buf_load_a: assert property (bufLoad &
		(periAddr == ADDR_COUNT_VALUE) |=> bufRData == $past(count))
		else $error("count load wrong");

	timed_done_c: cover property ((state == ST_TIMED) ##1 (state == ST_IDLE));
	ext_done_c:   cover property ((state == ST_EXT) ##1 (state == ST_IDLE));
	free_open_c:  cover property ((state == ST_FREE) & countInc);
	wrap_c:       cover property (countInc & (count == COUNT_MAX));
endmodule

// ===== bench/fgc_if_source.sv
`timescale 1ns/100ps
// *****
// Far-side IF and gate pulse source
// *****
module fgc_if_source (
	input  wire logic       core_clk,
	input  wire logic [7:0] amHalf,
	input  wire logic [7:0] fmHalf,
	input  wire logic [7:0] gateHalf,
	output logic            amInputPin,
	output logic            fmInputPin,
	output logic            gatePin0,
	output logic            gatePin1
);
	logic [7:0] amCnt = 8'h00;
	logic [7:0] fmCnt = 8'h00;
	logic [7:0] gCnt  = 8'h00;
	initial begin
		amInputPin = 1'b0;
		fmInputPin = 1'b0;
		gatePin0   = 1'b0;
	end
	// Second pin runs in antiphase, so a wrong pin choice shifts the gate
	assign gatePin1 = ~gatePin0;
	// Falling edge moves, so the core samples settled levels
	always @(negedge core_clk) begin
		amCnt <= (amCnt + 8'h01 >= amHalf) ? 8'h00 : amCnt + 8'h01;
		fmCnt <= (fmCnt + 8'h01 >= fmHalf) ? 8'h00 : fmCnt + 8'h01;
		gCnt  <= (gCnt + 8'h01 >= gateHalf) ? 8'h00 : gCnt + 8'h01;
		if (amCnt + 8'h01 >= amHalf) amInputPin <= ~amInputPin;
		if (fmCnt + 8'h01 >= fmHalf) fmInputPin <= ~fmInputPin;
		if (gCnt + 8'h01 >= gateHalf) gatePin0 <= ~gatePin0;
	end
endmodule

// ===== bench/tb_fgc_gate_counter.sv
`timescale 1ns/100ps
module tb_fgc_gate_counter
	import fgc_pkg::*;
;
	localparam int   TK = 20;
	localparam int   MC = 4;
	localparam int   HC = 2;
	localparam       CTL = ADDR_COUNT_CONTROL;
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	logic            clockStop = 1'b0;
	logic [6:0]      periAddr = 7'h00;
	logic            winWrite = 1'b0;
	logic            winRead = 1'b0;
	logic            bufLoad = 1'b0;
	logic [3:0]      winWData = 4'h0;
	logic [1:0]      functionSel = FN_AM_DIRECT;
	logic [1:0]      gateTimeSel = GT_1MS;
	logic [1:0]      gatePinSel = 2'h2;
	logic [7:0]      amHalf = 8'h02;
	logic [7:0]      fmHalf = 8'h03;
	logic [7:0]      gateHalf = 8'h14;
	logic            fmInputPin, amInputPin, gatePin0, gatePin1;
	logic [3:0]      winRData;
	logic [15:0]     bufRData, cnt, cnt2;
	logic            gateOpen;
	int              errors = 0;
	int              tests_run = 0;
	int              k, h, n, len;
	logic [1:0]      fnTab [5] = '{FN_AM_DIRECT, FN_AM_DIRECT,
		FN_AM_DIRECT, FN_FM_HALVED, FN_FM_DIRECT};
	logic [1:0]      gtTab [5] = '{GT_1MS, GT_4MS, GT_8MS, GT_4MS, GT_1MS};
	int              divTab [3] = '{TK, MC, HC};

	always #20 core_clk = ~core_clk;

	fgc_gate_counter #(.TICK_CYC(TK), .MID_CYC(MC), .HIGH_CYC(HC))
		i_fgc_gate_counter (
		.core_clk(core_clk), .rst(rst), .clockStop(clockStop),
		.periAddr(periAddr), .winWrite(winWrite), .winRead(winRead),
		.winWData(winWData), .bufLoad(bufLoad),
		.functionSel(functionSel), .gateTimeSel(gateTimeSel),
		.gatePinSel(gatePinSel), .fmInputPin(fmInputPin),
		.amInputPin(amInputPin), .gatePin0(gatePin0),
		.gatePin1(gatePin1), .winRData(winRData),
		.bufRData(bufRData), .gateOpen(gateOpen));

	fgc_if_source i_fgc_if_source (
		.core_clk(core_clk), .amHalf(amHalf), .fmHalf(fmHalf),
		.gateHalf(gateHalf), .amInputPin(amInputPin),
		.fmInputPin(fmInputPin), .gatePin0(gatePin0),
		.gatePin1(gatePin1));

	// *****
	// Shared tasks
	// *****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] d);
		@(negedge core_clk);
		periAddr = CTL;
		winWData = d;
		winWrite = 1'b1;
		@(negedge core_clk);
		winWrite = 1'b0;
	endtask
	// Window read or buffer load; result taken once the register settled
	task automatic acc(input bit isLoad, input logic [6:0] a,
		output logic [15:0] d);
		@(negedge core_clk);
		periAddr = a;
		if (isLoad) bufLoad = 1'b1;
		else winRead = 1'b1;
		@(negedge core_clk);
		bufLoad = 1'b0;
		winRead = 1'b0;
		@(negedge core_clk);
		d = isLoad ? bufRData : {12'h000, winRData};
	endtask
	task automatic gate_len(input int lim, output int m);
		int i;
		m = 0;
		for (i = 0; i < lim && gateOpen !== 1'b1; i++) @(negedge core_clk);
		while (gateOpen === 1'b1 && m < 400) begin
			@(negedge core_clk);
			m++;
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		errors++;
		end_sim();
	end

	// *****
	// Main sequence
	// *****
	initial begin
		void'($urandom(1));
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		check(bufRData, 16'h0000);
		check(16'(gateOpen), 16'h0000);
		acc(0, ADDR_GATE_STATUS, cnt);
		check(cnt, 16'h0000);
		acc(0, CTL, cnt);
		check(cnt, 16'h0000);
		acc(0, 7'h11, cnt);
		check(cnt, 16'h0000);
		for (k = 0; k < 5; k++) begin
			functionSel = fnTab[k];
			gateTimeSel = gtTab[k];
			len = (gtTab[k] == GT_1MS) ? 1 : (gtTab[k] == GT_4MS) ? 4 : 8;
			h = (fnTab[k] == FN_FM_HALVED) ? 1 : $urandom_range(1, 2);
			amHalf = (fnTab[k] == FN_AM_DIRECT) ? 8'(h) : 8'h03;
			fmHalf = (fnTab[k] == FN_AM_DIRECT) ? 8'h03 : 8'(h);
			repeat (4 + $urandom_range(0, 30)) @(negedge core_clk);
			if ($urandom_range(0, 1)) wr(4'h3);
			else begin
				wr(4'h1);
				wr(4'h2);
			end
			fork
				gate_len(TK + 3, n);
				acc(0, ADDR_GATE_STATUS, cnt);
			join
			check(cnt, 16'h0001);
			check(16'(n), 16'(len * TK));
			acc(0, ADDR_GATE_STATUS, cnt);
			check(cnt, 16'h0000);
			acc(1, ADDR_COUNT_VALUE, cnt);
			check(cnt, 16'(len * TK / (2 * h) / (k == 3 ? 2 : 1)));
			wr(4'h0);
			repeat (30) @(negedge core_clk);
			check(16'(gateOpen), 16'h0000);
			acc(1, ADDR_GATE_STATUS, cnt2);
			check(cnt2, cnt);
			acc(1, ADDR_COUNT_VALUE, cnt2);
			check(cnt2, cnt);
		end
		// Clock-stop reset in mid gate
		gateTimeSel = GT_8MS;
		wr(4'h2);
		repeat (TK + 30) @(negedge core_clk);
		clockStop = 1'b1;
		@(negedge core_clk);
		clockStop = 1'b0;
		check(16'(gateOpen), 16'h0000);
		acc(1, ADDR_COUNT_VALUE, cnt);
		check(cnt, 16'h0000);
		// *****
		// Open gate
		// *****
		functionSel = FN_AM_DIRECT;
		amHalf = 8'h02;
		gateTimeSel = GT_OPEN;
		repeat (3) @(negedge core_clk);
		check(16'(gateOpen), 16'h0001);
		wr(4'h1);
		acc(1, ADDR_COUNT_VALUE, cnt);
		check(16'(cnt < 16'h0002), 16'h0001);
		repeat (37) @(negedge core_clk);
		acc(1, ADDR_COUNT_VALUE, cnt2);
		check(cnt2 - cnt, 16'd10);
		gateTimeSel = GT_1MS;
		repeat (3) @(negedge core_clk);
		check(16'(gateOpen), 16'h0000);
		gateTimeSel = GT_OPEN;
		repeat (3) @(negedge core_clk);
		functionSel = FN_EXT_GATE;
		acc(1, ADDR_COUNT_VALUE, cnt);
		repeat (20) @(negedge core_clk);
		acc(1, ADDR_COUNT_VALUE, cnt2);
		check(cnt2, cnt);
		check(16'(gateOpen), 16'h0001);
		functionSel = FN_AM_DIRECT;
		gateTimeSel = GT_1MS;
		repeat (3) @(negedge core_clk);
		gateTimeSel = GT_OPEN;
		repeat (3) @(negedge core_clk);
		wr(4'h2);
		repeat (2 * TK + 10) @(negedge core_clk);
		check(16'(gateOpen), 16'h0000);
		// *****
		// External gate, one reference per pass
		// *****
		functionSel = FN_EXT_GATE;
		for (k = 0; k < 3; k++) begin
			gateTimeSel = gtTab[k];
			gatePinSel = k[0] ? GP_PIN1 : GP_PIN0;
			wr(4'h3);
			gate_len(2 * 20 + 4, n);
			check(16'(n), 16'd40);
			acc(1, ADDR_COUNT_VALUE, cnt);
			check(cnt, 16'(40 / divTab[k]));
		end
		end_sim();
	end
endmodule
